// file: src/ebp_pkg.sv
package ebp_pkg;
   // bus cycle phases, counted in clocks of the core clock
   localparam int unsigned ALE_CYCLES    = 1;  // latch strobe width
   localparam int unsigned SETUP_CYCLES  = 1;  // address hold after latch
   localparam int unsigned STROBE_CYCLES = 2;  // read/write/fetch strobe width
   localparam int unsigned HOLD_CYCLES   = 1;  // data hold after strobe
   localparam logic [1:0]  CNT_ALE       = 2'(ALE_CYCLES - 1);
   localparam logic [1:0]  CNT_SETUP     = 2'(SETUP_CYCLES - 1);
   localparam logic [1:0]  CNT_STROBE    = 2'(STROBE_CYCLES - 1);
   localparam logic [1:0]  CNT_HOLD      = 2'(HOLD_CYCLES - 1);
   localparam logic [15:0] ADDR_RST      = 16'h0000;
   localparam logic [7:0]  DATA_RST      = 8'h00;
   localparam logic [15:0] CODE_TOP      = 16'hffff; // external code reach

   // kind of bus cycle requested by the core
   typedef enum logic [1:0] {
      EBP_CODE  = 2'b00,
      EBP_READ  = 2'b01,
      EBP_WRITE = 2'b10
   } ebp_kind_t;

   typedef enum logic [2:0] {
      EBP_IDLE   = 3'b000,
      EBP_ALE    = 3'b001,
      EBP_SETUP  = 3'b010,
      EBP_STROBE = 3'b011,
      EBP_HOLD   = 3'b100
   } ebp_state_t;
endpackage : ebp_pkg

// file: src/ebp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the synchronised straps and data pins from the sampler
interface ebp_sync_if;
   logic       ext_code_n;
   logic       boot_sel_n;
   logic [7:0] data_low;
   logic [7:0] data_high;
   modport sampler (output ext_code_n, boot_sel_n, data_low, data_high);
   modport user    (input  ext_code_n, boot_sel_n, data_low, data_high);
endinterface : ebp_sync_if
`default_nettype wire

// file: src/ebp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_pin_sync
   import ebp_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ext_code_n_i,
   input  wire logic       boot_sel_n_i,
   input  wire logic [7:0] data_low_i,
   input  wire logic [7:0] data_high_i,
   ebp_sync_if.sampler     sync
);
   logic [17:0] meta_r;
   logic [17:0] meta_nxt;
   logic [17:0] stab_r;
   logic [17:0] stab_nxt;

   // two flops per pin; the first stage feeds only the second
   always_comb begin
      meta_nxt = {ext_code_n_i, boot_sel_n_i, data_high_i, data_low_i};
      stab_nxt = meta_r;
   end

   // straps reset to their inactive (high) level
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         meta_r <= {2'h3, 16'h0000};
         stab_r <= {2'h3, 16'h0000};
      end else begin
         meta_r <= meta_nxt;
         stab_r <= stab_nxt;
      end
   end

   assign sync.ext_code_n = stab_r[17];
   assign sync.boot_sel_n = stab_r[16];
   assign sync.data_high  = stab_r[15:8];
   assign sync.data_low   = stab_r[7:0];
endmodule : ebp_pin_sync
`default_nettype wire

// file: src/ebp_external_bus_port.sv
// Functional notes
// - pulse address latch strobe at cycle start while low address is valid
// - low lines carry low address first, then the data byte
// - high lines carry upper address; in ide mode they also carry data
// - code fetch strobe low during code fetch and code table reads
// - read strobe asserted only during external data reads
// - write strobe asserted only during external data writes
// - external code select low makes all code fetches external
// - boot select low at reset release starts the internal bootloader
// - upper address bits are actively driven, left floating only while ide reads take data
`timescale 1ns/1ps
`default_nettype none
module ebp_external_bus_port
   import ebp_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // core side request
   input  wire logic       req_valid_i,
   output logic            req_ready_o,
   input  wire ebp_kind_t  req_kind_i,
   input  wire logic       req_ide_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_wdata_i,
   output logic            rsp_valid_o,
   output logic [15:0]     rsp_rdata_o,
   // strap status
   output logic            fetch_external_o,
   output logic            boot_loader_o,
   // bus pins
   output logic            addr_latch_o,
   output logic            code_fetch_strobe_n_o,
   output logic            read_strobe_n_o,
   output logic            write_strobe_n_o,
   output logic [7:0]      addr_data_low_o,
   output logic [7:0]      addr_data_low_oe_o,
   input  wire logic [7:0] addr_data_low_i,
   output logic [7:0]      addr_high_o,
   output logic [7:0]      addr_high_oe_o,
   input  wire logic [7:0] addr_high_i,
   input  wire logic       external_code_select_n_i,
   input  wire logic       boot_loader_select_n_i
);
   ebp_sync_if sync ();

   ebp_pin_sync u_sync (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .ext_code_n_i (external_code_select_n_i),
      .boot_sel_n_i (boot_loader_select_n_i),
      .data_low_i   (addr_data_low_i),
      .data_high_i  (addr_high_i),
      .sync         (sync)
   );

   ebp_state_t  state_r,  state_nxt;
   logic [1:0]  cnt_r,    cnt_nxt;
   ebp_kind_t   kind_r,   kind_nxt;
   logic        ide_r,    ide_nxt;
   logic [15:0] addr_r,   addr_nxt;
   logic [15:0] wdata_r,  wdata_nxt;
   logic [15:0] rdata_r,  rdata_nxt;
   logic        rvld_r,   rvld_nxt;
   logic        ale_r,    ale_nxt;
   logic        cfs_n_r,  cfs_n_nxt;
   logic        rd_n_r,   rd_n_nxt;
   logic        wr_n_r,   wr_n_nxt;
   logic [7:0]  low_r,    low_nxt;
   logic        low_oe_r, low_oe_nxt;
   logic [7:0]  high_r,   high_nxt;
   logic        high_oe_r, high_oe_nxt;
   logic        boot_r,   boot_nxt;
   logic        armed_r,  armed_nxt;
   logic        ext_r,    ext_nxt;

   // bus cycle sequencer: latch, setup, strobe, hold
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      kind_nxt    = kind_r;
      ide_nxt     = ide_r;
      addr_nxt    = addr_r;
      wdata_nxt   = wdata_r;
      rdata_nxt   = rdata_r;
      rvld_nxt    = 1'b0;
      ale_nxt     = 1'b0;
      cfs_n_nxt   = 1'b1;
      rd_n_nxt    = 1'b1;
      wr_n_nxt    = 1'b1;
      low_nxt     = low_r;
      low_oe_nxt  = low_oe_r;
      high_nxt    = high_r;
      high_oe_nxt = high_oe_r;
      case (state_r)
         EBP_IDLE: begin
            if (req_valid_i) begin
               kind_nxt    = req_kind_i;
               ide_nxt     = req_ide_i;
               addr_nxt    = req_addr_i;
               wdata_nxt   = req_wdata_i;
               ale_nxt     = 1'b1;
               low_nxt     = req_addr_i[7:0];
               low_oe_nxt  = 1'b1;
               high_nxt    = req_addr_i[15:8];
               high_oe_nxt = 1'b1;
               cnt_nxt     = CNT_ALE;
               state_nxt   = EBP_ALE;
            end
         end
         EBP_ALE: begin
            ale_nxt = (cnt_r != 2'h0);
            if (cnt_r != 2'h0) begin
               cnt_nxt = cnt_r - 2'h1;
            end else begin
               cnt_nxt   = CNT_SETUP;
               state_nxt = EBP_SETUP;
            end
         end
         EBP_SETUP: begin
            if (cnt_r != 2'h0) begin
               cnt_nxt = cnt_r - 2'h1;
            end else begin
               // low lines turn over from address to data
               if (kind_r == EBP_WRITE) begin
                  low_nxt = wdata_r[7:0];
                  if (ide_r) begin
                     high_nxt = wdata_r[15:8];
                  end
               end else begin
                  low_oe_nxt = 1'b0;
                  if (ide_r) begin
                     high_oe_nxt = 1'b0;
                  end
               end
               // exactly one strobe per cycle
               cfs_n_nxt = (kind_r != EBP_CODE);
               rd_n_nxt  = (kind_r != EBP_READ);
               wr_n_nxt  = (kind_r != EBP_WRITE);
               cnt_nxt   = CNT_STROBE;
               state_nxt = EBP_STROBE;
            end
         end
         EBP_STROBE: begin
            if (cnt_r != 2'h0) begin
               cfs_n_nxt = cfs_n_r;
               rd_n_nxt  = rd_n_r;
               wr_n_nxt  = wr_n_r;
               cnt_nxt   = cnt_r - 2'h1;
            end else begin
               cnt_nxt   = CNT_HOLD;
               state_nxt = EBP_HOLD;
            end
         end
         EBP_HOLD: begin
            if (cnt_r != 2'h0) begin
               cnt_nxt = cnt_r - 2'h1;
            end else begin
               // the synchroniser lags two clocks, so what it shows now was
               // on the lines while the strobe was still low
               rdata_nxt   = {ide_r ? sync.data_high : 8'h00, sync.data_low};
               rvld_nxt    = (kind_r != EBP_WRITE);
               low_oe_nxt  = 1'b0;
               high_nxt    = addr_r[15:8];
               high_oe_nxt = 1'b1;
               state_nxt   = EBP_IDLE;
            end
         end
         default: begin
            state_nxt = EBP_IDLE;
         end
      endcase
   end

   // the synchroniser needs two clocks before a strap is valid, so the
   // boot choice lands on the fourth edge after release
   logic [1:0] wait_r, wait_nxt;

   // straps: boot choice caught once, in the first cycles after reset
   always_comb begin
      wait_nxt  = (wait_r == 2'h3) ? wait_r : wait_r + 2'h1;
      armed_nxt = (wait_r == 2'h2);
      boot_nxt  = boot_r;
      ext_nxt   = ~sync.ext_code_n;
      if (armed_r) begin
         boot_nxt = ~sync.boot_sel_n;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r   <= EBP_IDLE;
         cnt_r     <= 2'h0;
         kind_r    <= EBP_CODE;
         ide_r     <= 1'b0;
         addr_r    <= ADDR_RST;
         wdata_r   <= ADDR_RST;
         rdata_r   <= ADDR_RST;
         rvld_r    <= 1'b0;
         ale_r     <= 1'b0;
         cfs_n_r   <= 1'b1;
         rd_n_r    <= 1'b1;
         wr_n_r    <= 1'b1;
         low_r     <= DATA_RST;
         low_oe_r  <= 1'b0;
         high_r    <= DATA_RST;
         high_oe_r <= 1'b1;
         boot_r    <= 1'b0;
         armed_r   <= 1'b0;
         ext_r     <= 1'b0;
         wait_r    <= 2'h0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         kind_r    <= kind_nxt;
         ide_r     <= ide_nxt;
         addr_r    <= addr_nxt;
         wdata_r   <= wdata_nxt;
         rdata_r   <= rdata_nxt;
         rvld_r    <= rvld_nxt;
         ale_r     <= ale_nxt;
         cfs_n_r   <= cfs_n_nxt;
         rd_n_r    <= rd_n_nxt;
         wr_n_r    <= wr_n_nxt;
         low_r     <= low_nxt;
         low_oe_r  <= low_oe_nxt;
         high_r    <= high_nxt;
         high_oe_r <= high_oe_nxt;
         boot_r    <= boot_nxt;
         armed_r   <= armed_nxt;
         ext_r     <= ext_nxt;
         wait_r    <= wait_nxt;
      end
   end

   assign req_ready_o           = (state_r == EBP_IDLE);
   assign rsp_valid_o           = rvld_r;
   assign rsp_rdata_o           = rdata_r;
   assign fetch_external_o      = ext_r;
   assign boot_loader_o         = boot_r;
   assign addr_latch_o          = ale_r;
   assign code_fetch_strobe_n_o = cfs_n_r;
   assign read_strobe_n_o       = rd_n_r;
   assign write_strobe_n_o      = wr_n_r;
   assign addr_data_low_o       = low_r;
   assign addr_data_low_oe_o    = {8{low_oe_r}};
   assign addr_high_o           = high_r;
   assign addr_high_oe_o        = {8{high_oe_r}};
endmodule : ebp_external_bus_port
`default_nettype wire

// file: test/ebp_bus_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_bus_checker
   import ebp_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        req_valid_i,
   input wire logic        req_ready_o,
   input wire ebp_kind_t   req_kind_i,
   input wire logic [15:0] req_addr_i,
   input wire logic        rsp_valid_o,
   input wire logic        fetch_external_o,
   input wire logic        addr_latch_o,
   input wire logic        code_fetch_strobe_n_o,
   input wire logic        read_strobe_n_o,
   input wire logic        write_strobe_n_o,
   input wire logic [7:0]  addr_data_low_o,
   input wire logic [7:0]  addr_data_low_oe_o,
   input wire logic [7:0]  addr_high_o,
   input wire logic [7:0]  addr_high_oe_o,
   input wire logic        external_code_select_n_i
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // a request is taken on an edge where both sides agree
   wire logic tk = req_valid_i && req_ready_o;
   property p_latch;
      tk |=> addr_latch_o ##1 !addr_latch_o;
   endproperty
   a_latch: assert property (p_latch) else $error("latch pulse wrong");
   property p_low;
      tk |=> addr_data_low_o == $past(req_addr_i[7:0]) && &addr_data_low_oe_o;
   endproperty
   a_low: assert property (p_low) else $error("low address wrong");
   property p_high;
      addr_latch_o |-> addr_high_o == $past(req_addr_i[15:8]) && &addr_high_oe_o;
   endproperty
   a_high: assert property (p_high) else $error("high address wrong");
   property p_code;
      tk && req_kind_i == EBP_CODE |->
         ##3 !code_fetch_strobe_n_o [*2] ##1 code_fetch_strobe_n_o;
   endproperty
   a_code: assert property (p_code) else $error("fetch strobe wrong");
   property p_read;
      tk && req_kind_i == EBP_READ |->
         ##3 !read_strobe_n_o [*2] ##1 read_strobe_n_o;
   endproperty
   a_read: assert property (p_read) else $error("read strobe wrong");
   property p_write;
      tk && req_kind_i == EBP_WRITE |->
         ##3 !write_strobe_n_o [*2] ##1 write_strobe_n_o;
   endproperty
   a_write: assert property (p_write) else $error("write strobe wrong");
   property p_one;
      $onehot0({~code_fetch_strobe_n_o, ~read_strobe_n_o, ~write_strobe_n_o});
   endproperty
   a_one: assert property (p_one) else $error("two strobes at once");
   property p_rsp;
      tk && req_kind_i != EBP_WRITE |-> ##6 rsp_valid_o;
   endproperty
   a_rsp: assert property (p_rsp) else $error("answer late");
   property p_busy;
      !read_strobe_n_o || !write_strobe_n_o |-> !req_ready_o;
   endproperty
   a_busy: assert property (p_busy) else $error("ready in strobe");
   property p_fext;
      !external_code_select_n_i [*5] |-> fetch_external_o;
   endproperty
   a_fext: assert property (p_fext) else $error("fetch status wrong");
   // main traffic kinds seen
   c_code: cover property (tk && req_kind_i == EBP_CODE);
   c_read: cover property (tk && req_kind_i == EBP_READ);
   c_write: cover property (tk && req_kind_i == EBP_WRITE);
endmodule : ebp_bus_checker
`default_nettype wire

// file: test/ebp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_mem_model (
   input  wire logic       ref_clk_i,
   input  wire logic       ale_i,
   input  wire logic       code_n_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic [7:0] lo_i,
   input  wire logic [7:0] lo_oe_i,
   input  wire logic [7:0] hi_i,
   input  wire logic [7:0] hi_oe_i,
   output logic [7:0]      lo_o,
   output logic [7:0]      hi_o
);
   logic [7:0] mem_lo [256];
   logic [7:0] mem_hi [256];
   logic [7:0] lat = 8'h00;
   logic [7:0] last_lo = 8'h00;
   logic [7:0] last_hi = 8'h00;
   wire logic  rd = !rd_n_i || !code_n_i;
   // released lines toggle so stale data never looks valid
   assign lo_o = (lo_i & lo_oe_i) | ((rd ? mem_lo[lat] : ~last_lo) & ~lo_oe_i);
   assign hi_o = (hi_i & hi_oe_i) | ((rd ? mem_hi[lat] : ~last_hi) & ~hi_oe_i);
   initial for (int i = 0; i < 256; i++) begin
      mem_lo[i] = 8'(i) ^ 8'h3c;
      mem_hi[i] = ~8'(i);
   end
   // latch the low address on the strobe, store writes
   always @(posedge ref_clk_i) begin
      last_lo <= lo_o;
      last_hi <= hi_o;
      if (ale_i) lat <= lo_o;
      if (!wr_n_i) begin
         mem_lo[lat] <= lo_o;
         mem_hi[lat] <= hi_o;
      end
   end
endmodule : ebp_mem_model
`default_nettype wire

// file: test/tb_ebp_external_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ebp_external_bus_port;
   import ebp_pkg::*;
   logic        clk = 0, rst = 1, vld = 0, ide = 0, ext_n = 0, boot_n = 0;
   ebp_kind_t   kind = EBP_READ;
   logic [15:0] addr = 16'h0000, wd = 16'h0000, rdata, r;
   logic        rdy, rspv, fext, boot, ale, psn, rdn, wrn;
   logic [7:0]  lo_o, lo_oe, lo_i, hi_o, hi_oe, hi_i;
   logic [7:0]  sh_lo [256];
   logic [7:0]  sh_hi [256];
   int          failures = 0, check_count = 0;
   integer      seed = 32'ha8e8;
   initial forever #12.5 clk = ~clk;
   ebp_external_bus_port i_ebp_external_bus_port (
      .ref_clk_i(clk), .rst_i(rst), .req_valid_i(vld), .req_ready_o(rdy),
      .req_kind_i(kind), .req_ide_i(ide), .req_addr_i(addr),
      .req_wdata_i(wd), .rsp_valid_o(rspv), .rsp_rdata_o(rdata),
      .fetch_external_o(fext), .boot_loader_o(boot), .addr_latch_o(ale),
      .code_fetch_strobe_n_o(psn), .read_strobe_n_o(rdn),
      .write_strobe_n_o(wrn), .addr_data_low_o(lo_o),
      .addr_data_low_oe_o(lo_oe), .addr_data_low_i(lo_i),
      .addr_high_o(hi_o), .addr_high_oe_o(hi_oe), .addr_high_i(hi_i),
      .external_code_select_n_i(ext_n), .boot_loader_select_n_i(boot_n));
   ebp_mem_model i_ebp_mem_model (
      .ref_clk_i(clk), .ale_i(ale), .code_n_i(psn), .rd_n_i(rdn),
      .wr_n_i(wrn), .lo_i(lo_o), .lo_oe_i(lo_oe), .hi_i(hi_o),
      .hi_oe_i(hi_oe), .lo_o(lo_i), .hi_o(hi_i));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task finish_test;
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // one bus cycle; reads are compared against the shadow memory
   task xfer(input ebp_kind_t k, input logic i, input logic [15:0] a, d);
      int n;
      @(negedge clk);
      vld = 1; kind = k; ide = i; addr = a; wd = d;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      @(negedge clk);
      vld = 0;
      if (k != EBP_WRITE) begin
         while (rspv !== 1'b1 && n < 28) begin @(negedge clk); n++; end
         check(rdata, {i ? sh_hi[a[7:0]] : 8'h00, sh_lo[a[7:0]]});
      end else begin
         sh_lo[a[7:0]] = d[7:0];
         sh_hi[a[7:0]] = i ? d[15:8] : a[15:8];
      end
      if (n >= 20) begin failures++; finish_test; end
   endtask : xfer
   initial begin
      for (int j = 0; j < 256; j++) begin
         sh_lo[j] = 8'(j) ^ 8'h3c;
         sh_hi[j] = ~8'(j);
      end
      repeat (5) @(negedge clk);
      rst = 0;
      repeat (6) @(negedge clk);
      check(16'(boot), 16'h0001);
      check(16'(fext), 16'h0001);
      ext_n = 1;
      repeat (5) @(negedge clk);
      check(16'(fext), 16'h0000);
      ext_n = 0;
      // boundary addresses, back to back, both widths
      xfer(EBP_WRITE, 0, 16'hffff, 16'h00a5);
      xfer(EBP_READ, 1, 16'hffff, 16'h0000);
      xfer(EBP_CODE, 0, 16'h0000, 16'h0000);
      xfer(EBP_WRITE, 1, 16'h12ff, 16'h5a3c);
      xfer(EBP_CODE, 1, 16'hffff, 16'h0000);
      for (int j = 0; j < 60; j++) begin
         r = 16'($random(seed));
         xfer(ebp_kind_t'(2'($unsigned($random(seed)) % 3)), r[4],
              {r[15:8], 4'h0, r[3:0]}, 16'($random(seed)));
      end
      // second reset with the boot pin released
      @(negedge clk);
      rst = 1;
      boot_n = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      repeat (6) @(negedge clk);
      check(16'(boot), 16'h0000);
      // the pin is only looked at around reset release
      boot_n = 0;
      repeat (6) @(negedge clk);
      check(16'(boot), 16'h0000);
      xfer(EBP_READ, 0, 16'h0012, 16'h0000);
      finish_test;
   end
endmodule : tb_ebp_external_bus_port
bind ebp_external_bus_port ebp_bus_checker i_ebp_bus_checker (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
   .req_ready_o(req_ready_o), .req_kind_i(req_kind_i),
   .req_addr_i(req_addr_i), .rsp_valid_o(rsp_valid_o),
   .fetch_external_o(fetch_external_o), .addr_latch_o(addr_latch_o),
   .code_fetch_strobe_n_o(code_fetch_strobe_n_o),
   .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
   .addr_data_low_o(addr_data_low_o),
   .addr_data_low_oe_o(addr_data_low_oe_o), .addr_high_o(addr_high_o),
   .addr_high_oe_o(addr_high_oe_o),
   .external_code_select_n_i(external_code_select_n_i));
`default_nettype wire
